// File: common/pmst_defs.vh
`ifndef PMST_DEFS_VH
`define PMST_DEFS_VH

`define PMST_ADDR_POWER_MODE   8'h2D
`define PMST_ADDR_SELF_CHECK   8'h2E
`define PMST_RST_POWER_MODE    8'h00
`define PMST_RST_SELF_CHECK    8'h00

`define PMST_BIT_CONV_EN       7
`define PMST_BIT_OUTSIDE_CLK   6
`define PMST_NOISE_HI          5
`define PMST_NOISE_LO          4
`define PMST_BIT_WAKE          3
`define PMST_BIT_AUTO_DOZE     2
`define PMST_RUN_HI            1
`define PMST_RUN_LO            0
`define PMST_BIT_FORCE         0

`define PMST_NOISE_NORMAL      2'h0
`define PMST_NOISE_LOW         2'h1
`define PMST_NOISE_ULTRA       2'h2
`define PMST_RUN_STANDBY       2'h0
`define PMST_RUN_RUN_STATE       2'h2

`define PMST_ODR_12HZ5         3'h0
`define PMST_ODR_400HZ         3'h5
`define PMST_WAKE_DIV          7'h40

`define PMST_CLK_PERIOD_NS     4
`define PMST_BASE_PERIOD_US    2500
`define PMST_EXT_PER_BASE      128

`endif

// File: src/pmst_pin_sync.v
`timescale 1ns/1ps
module pmst_pin_sync (
	input  wire core_clk_i,
	input  wire rst_n_i,
	input  wire pin_i,
	output reg  level_o,
	output reg  rise_o
);

	reg s1_r;
	reg s2_r;
	reg s3_r;

	// A change counts only once the second and third stages agree.
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_o <= 1'b0;
			rise_o  <= 1'b0;
		end else begin
			s1_r   <= pin_i;
			s2_r   <= s1_r;
			s3_r   <= s2_r;
			rise_o <= 1'b0;
			if (s2_r == s3_r) begin
				level_o <= s3_r;
				rise_o  <= s3_r & ~level_o;
			end
		end
	end

endmodule

// File: src/pmst_power_ctrl.v
`timescale 1ns/1ps
`include "pmst_defs.vh"

module pmst_power_ctrl #(
	parameter integer BASE_CYCLES   = (`PMST_BASE_PERIOD_US * 1000) / `PMST_CLK_PERIOD_NS,
	parameter integer EXT_PER_BASE  = `PMST_EXT_PER_BASE
) (
	input  wire       core_clk_i,
	input  wire       rst_n_i,
	input  wire [7:0] reg_addr_i,
	input  wire [7:0] reg_wdata_i,
	input  wire       reg_wr_i,
	input  wire       reg_rd_i,
	output reg  [7:0] reg_rdata_o,
	output reg        reg_hit_o,
	input  wire [2:0] output_rate_i,
	input  wire       trigger_sampling_i,
	input  wire       motion_link_loop_i,
	input  wire       inactivity_i,
	input  wire       first_interrupt_pin_i,
	input  wire       second_interrupt_pin_i,
	output reg        sample_strobe_o,
	output reg        convert_strobe_o,
	output reg        converter_on_o,
	output reg  [1:0] noise_mode_o,
	output reg        measuring_o,
	output reg        wake_active_o,
	output reg        force_apply_o,
	output reg  [2:0] filter_rate_o,
	output reg        trigger_input_o
);

	reg  [7:0]  power_mode_control_r;
	reg  [7:0]  self_check_control_r;
	reg  [19:0] base_cnt_r;
	reg  [7:0]  ext_cnt_r;
	reg  [6:0]  rate_cnt_r;
	reg         base_tick;
	reg         measuring_nxt;
	reg         wake_nxt;
	reg         sample_nxt;
	reg  [6:0]  div_nxt;
	wire        outside_clock_select_level;
	wire        outside_clock_select_rise;
	wire        trig_level;
	wire        trig_rise;
	wire        outside_clock_select;
	wire        trig_mode;

	// Divisor of the 400 Hz base tick for a rate code; wake-up uses about 6 Hz.
	function [6:0] pmst_rate_div;
		input [2:0] code;
		input       wake;
		begin
			if (wake)
				pmst_rate_div = `PMST_WAKE_DIV;
			else if (code >= `PMST_ODR_400HZ)
				pmst_rate_div = 7'h01;
			else
				pmst_rate_div = 7'h01 << (3'h5 - code);
		end
	endfunction

	pmst_pin_sync u_outside_clock_select (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.pin_i      (first_interrupt_pin_i),
		.level_o    (outside_clock_select_level),
		.rise_o     (outside_clock_select_rise)
	);

	pmst_pin_sync u_trigger (
		.core_clk_i (core_clk_i),
		.rst_n_i    (rst_n_i),
		.pin_i      (second_interrupt_pin_i),
		.level_o    (trig_level),
		.rise_o     (trig_rise)
	);

	assign outside_clock_select = power_mode_control_r[`PMST_BIT_OUTSIDE_CLK];
	assign trig_mode            = trigger_sampling_i;

	// Register writes and registered read data.
	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			power_mode_control_r <= `PMST_RST_POWER_MODE;
			self_check_control_r <= `PMST_RST_SELF_CHECK;
			reg_rdata_o          <= 8'h00;
			reg_hit_o            <= 1'b0;
		end else begin
			reg_hit_o <= 1'b0;
			if (reg_wr_i && reg_addr_i == `PMST_ADDR_POWER_MODE)
				power_mode_control_r <= reg_wdata_i;
			if (reg_wr_i && reg_addr_i == `PMST_ADDR_SELF_CHECK)
				self_check_control_r <= reg_wdata_i;
			if (reg_rd_i) begin
				reg_hit_o <= (reg_addr_i == `PMST_ADDR_POWER_MODE) || (reg_addr_i == `PMST_ADDR_SELF_CHECK);
				case (reg_addr_i)
					`PMST_ADDR_POWER_MODE: reg_rdata_o <= power_mode_control_r;
					`PMST_ADDR_SELF_CHECK: reg_rdata_o <= self_check_control_r;
					default:               reg_rdata_o <= 8'h00;
				endcase
			end
		end
	end

	// Mode decode and sample timing.
	always @* begin
		measuring_nxt = (power_mode_control_r[`PMST_RUN_HI:`PMST_RUN_LO] == `PMST_RUN_RUN_STATE);
		wake_nxt      = measuring_nxt & (power_mode_control_r[`PMST_BIT_WAKE]
		                | (power_mode_control_r[`PMST_BIT_AUTO_DOZE] & motion_link_loop_i & inactivity_i));
		if (outside_clock_select)
			base_tick = outside_clock_select_rise && (ext_cnt_r == EXT_PER_BASE[7:0] - 8'h01);
		else
			base_tick = (base_cnt_r == BASE_CYCLES[19:0] - 20'h00001);
		div_nxt = pmst_rate_div(output_rate_i, wake_nxt);
		if (trig_mode)
			sample_nxt = measuring_nxt & trig_rise;
		else
			sample_nxt = measuring_nxt & base_tick & (rate_cnt_r >= div_nxt - 7'h01);
	end

	always @(posedge core_clk_i) begin
		if (!rst_n_i) begin
			base_cnt_r       <= 20'h00000;
			ext_cnt_r        <= 8'h00;
			rate_cnt_r       <= 7'h00;
			sample_strobe_o  <= 1'b0;
			convert_strobe_o <= 1'b0;
			converter_on_o   <= 1'b0;
			noise_mode_o     <= `PMST_NOISE_NORMAL;
			measuring_o      <= 1'b0;
			wake_active_o    <= 1'b0;
			force_apply_o    <= 1'b0;
			filter_rate_o    <= `PMST_ODR_12HZ5;
			trigger_input_o  <= 1'b0;
		end else begin
			if (outside_clock_select || base_tick)
				base_cnt_r <= 20'h00000;
			else
				base_cnt_r <= base_cnt_r + 20'h00001;
			if (!outside_clock_select)
				ext_cnt_r <= 8'h00;
			else if (outside_clock_select_rise)
				ext_cnt_r <= base_tick ? 8'h00 : ext_cnt_r + 8'h01;
			if (!measuring_nxt || trig_mode || sample_nxt)
				rate_cnt_r <= 7'h00;
			else if (base_tick)
				rate_cnt_r <= rate_cnt_r + 7'h01;
			sample_strobe_o  <= sample_nxt;
			convert_strobe_o <= sample_nxt & power_mode_control_r[`PMST_BIT_CONV_EN];
			converter_on_o   <= power_mode_control_r[`PMST_BIT_CONV_EN];
			noise_mode_o     <= power_mode_control_r[`PMST_NOISE_HI:`PMST_NOISE_LO];
			measuring_o      <= measuring_nxt;
			wake_active_o    <= wake_nxt;
			force_apply_o    <= self_check_control_r[`PMST_BIT_FORCE];
			filter_rate_o    <= output_rate_i;
			trigger_input_o  <= trig_mode & trig_level;
		end
	end

endmodule

// File: src/README_unused.v
`timescale 1ns/1ps

// File: verif/pmst_props.sv
`timescale 1ns/1ps
module pmst_props (
	input wire       core_clk_i,
	input wire       rst_n_i,
	input wire [7:0] reg_addr_i,
	input wire [7:0] reg_wdata_i,
	input wire       reg_wr_i,
	input wire       motion_link_loop_i,
	input wire       inactivity_i,
	input wire       trigger_sampling_i,
	input wire       second_interrupt_pin_i,
	input wire       sample_strobe_o,
	input wire       convert_strobe_o,
	input wire       converter_on_o,
	input wire [1:0] noise_mode_o,
	input wire       measuring_o,
	input wire       wake_active_o,
	input wire       force_apply_o,
	input wire       trigger_input_o
);
	default clocking @(posedge core_clk_i);
	endclocking
	default disable iff (!rst_n_i);
	wire wp = reg_wr_i && reg_addr_i == 8'h2D;
	AST_CONV: assert property (convert_strobe_o |-> sample_strobe_o && converter_on_o)
		else $error("convert without sample");
	AST_NOISE: assert property (wp |-> ##2 noise_mode_o == $past(reg_wdata_i[5:4], 2))
		else $error("noise mode");
	AST_RUN: assert property (wp |-> ##2 measuring_o == ($past(reg_wdata_i[1:0], 2) == 2'h2))
		else $error("run state");
	AST_WAKE: assert property (wp && reg_wdata_i[3] && reg_wdata_i[1:0] == 2'h2 |-> ##2 wake_active_o)
		else $error("wake bit");
	AST_DOZE: assert property ($rose(wake_active_o) && !$past(reg_wr_i, 2)
		|-> $past(motion_link_loop_i && inactivity_i))
		else $error("doze entry");
	AST_FORCE: assert property (reg_wr_i && reg_addr_i == 8'h2E
		|-> ##2 force_apply_o == $past(reg_wdata_i[0], 2))
		else $error("force bit");
	AST_ONE: assert property (sample_strobe_o |=> !sample_strobe_o)
		else $error("strobe width");
	AST_TRIG: assert property (trigger_sampling_i && measuring_o && $rose(second_interrupt_pin_i) |-> ##[3:6] sample_strobe_o)
		else $error("trigger lost");
	AST_TPIN: assert property (trigger_input_o |-> $past(trigger_sampling_i))
		else $error("trigger pin use");
endmodule
bind pmst_power_ctrl pmst_props u_pmst_props (.*);

// File: verif/pmst_host_model.sv
`timescale 1ns/1ps
module pmst_host_model (
	input  wire clk_run_i,
	output reg  outside_clock_select_o,
	output reg  trig_o
);
	initial begin
		outside_clock_select_o = 1'b0;
		trig_o    = 1'b0;
		#3;
		forever begin
			#16;
			outside_clock_select_o = clk_run_i ? ~outside_clock_select_o : 1'b0;
		end
	end
	task pulse;
		begin
			trig_o = 1'b1;
			#40;
			trig_o = 1'b0;
			#40;
		end
	endtask
endmodule

// File: verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
	reg        core_clk_i = 1'b0;
	reg        rst_n_i = 1'b0;
	reg  [7:0] reg_addr_i = 8'h00;
	reg  [7:0] reg_wdata_i = 8'h00;
	reg        reg_wr_i = 1'b0;
	reg        reg_rd_i = 1'b0;
	reg  [2:0] output_rate_i = 3'h5;
	reg        trigger_sampling_i = 1'b0;
	reg        motion_link_loop_i = 1'b0;
	reg        inactivity_i = 1'b0;
	reg        run = 1'b0;
	wire [7:0] reg_rdata_o;
	wire [1:0] noise_mode_o;
	wire [2:0] filter_rate_o;
	wire       reg_hit_o, sample_strobe_o, convert_strobe_o, converter_on_o, measuring_o;
	wire       wake_active_o, force_apply_o, trigger_input_o, first_interrupt_pin_i, second_interrupt_pin_i;
	integer    err_count = 0;
	integer    n_checks = 0;
	integer    n;
	integer    i;
	pmst_power_ctrl #(.BASE_CYCLES(20), .EXT_PER_BASE(4)) u_pmst_power_ctrl (.*);
	pmst_host_model u_pmst_host_model (.clk_run_i(run), .outside_clock_select_o(first_interrupt_pin_i), .trig_o(second_interrupt_pin_i));
	initial forever #2 core_clk_i = ~core_clk_i;
	task chk(input [7:0] got, input [7:0] exp);
		begin
			n_checks = n_checks + 1;
			if (got !== exp) begin
				err_count = err_count + 1;
				$display("Error %0t: got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task chkn(input integer got, input integer lo, input integer hi);
		chk((got >= lo && got <= hi) ? 8'h01 : 8'h00, 8'h01);
	endtask
	task wreg(input [7:0] a, input [7:0] d);
		begin
			@(negedge core_clk_i);
			reg_addr_i = a;
			reg_wdata_i = d;
			reg_wr_i = 1'b1;
			@(negedge core_clk_i);
			reg_wr_i = 1'b0;
			@(negedge core_clk_i);
		end
	endtask
	task rreg(input [7:0] a, input [7:0] e, input h);
		begin
			@(negedge core_clk_i);
			reg_addr_i = a;
			reg_rd_i = 1'b1;
			@(negedge core_clk_i);
			reg_rd_i = 1'b0;
			chk(reg_rdata_o, e);
			chk({7'h00, reg_hit_o}, {7'h00, h});
		end
	endtask
	task gap(input integer e);
		begin
			for (n = 0; sample_strobe_o !== 1'b1 && n < 3000; n = n + 1) @(negedge core_clk_i);
			@(negedge core_clk_i);
			for (n = 1; sample_strobe_o !== 1'b1 && n < 3000; n = n + 1) @(negedge core_clk_i);
			chkn(n, e - 1, e + 1);
		end
	endtask
	task t_regs;
		begin
			rreg(8'h2D, 8'h00, 1'b1);
			rreg(8'h2E, 8'h00, 1'b1);
			wreg(8'h2D, 8'h8A);
			chk({converter_on_o, measuring_o, wake_active_o}, 8'h07);
			rreg(8'h2D, 8'h8A, 1'b1);
			wreg(8'h2E, 8'hFF);
			chk(force_apply_o, 8'h01);
			rreg(8'h2E, 8'hFF, 1'b1);
			rreg(8'h2F, 8'h00, 1'b0);
			for (i = 0; i < 4; i = i + 1) begin
				wreg(8'h2D, (i << 4) | 8'h02);
				chk(noise_mode_o, i);
			end
		end
	endtask
	task t_rate;
		begin
			wreg(8'h2D, 8'h82);
			repeat (4) gap(20);
			chk(convert_strobe_o, 8'h01);
			output_rate_i = 3'h4;
			gap(40);
			chk({5'h00, filter_rate_o}, 8'h04);
			output_rate_i = 3'h0;
			gap(640);
			output_rate_i = 3'h5;
			wreg(8'h2D, 8'h0A);
			gap(1280);
			chk(convert_strobe_o, 8'h00);
			wreg(8'h2D, 8'h42);
			run = 1'b1;
			gap(32);
			run = 1'b0;
		end
	endtask
	task t_doze;
		begin
			wreg(8'h2D, 8'h06);
			inactivity_i = 1'b1;
			repeat (3) @(negedge core_clk_i);
			chk(wake_active_o, 8'h00);
			motion_link_loop_i = 1'b1;
			repeat (3) @(negedge core_clk_i);
			chk(wake_active_o, 8'h01);
			inactivity_i = 1'b0;
		end
	endtask
	task t_trig;
		begin
			output_rate_i = 3'h0;
			trigger_sampling_i = 1'b1;
			wreg(8'h2D, 8'h02);
			i = 0;
			fork
				repeat (3) u_pmst_host_model.pulse;
				repeat (100) @(negedge core_clk_i) i = i + sample_strobe_o;
				begin
					repeat (8) @(negedge core_clk_i);
					chk(trigger_input_o, 8'h01);
				end
			join
			chkn(i, 3, 3);
		end
	endtask
	task close_out;
		begin
			$display("checks %0d errors %0d", n_checks, err_count);
			if (err_count == 0 && n_checks > 0)
				$display("NO MISMATCHES");
			else
				$display("MISMATCHES SEEN");
			$finish;
		end
	endtask
	initial begin
		#100000;
		err_count = err_count + 1;
		close_out;
	end
	initial begin
		repeat (20) @(negedge core_clk_i);
		rst_n_i = 1'b1;
		t_regs;
		t_rate;
		t_doze;
		t_trig;
		close_out;
	end
endmodule
